// ==== rtl/lsd_driver.sv ====
`timescale 1ns/1ns
// Summary of operation
// - Reset stops bias and driver; all common and segment pins float.
// - Selected segment pins drive ground until the display is enabled.
// - Config sets frame rate and duty; used commons drive ground while stopped.
// - Supports 1/3 and 1/4 duty and LCD waveform types A and B.
// - LED drive mode works at both duties and uses waveform type A only.
// - A non-stop display mode starts waveforms on all configured pins.
// - Mode 00 means stopped; segment selection changes only while stopped.
// - Data bit 0 picks the drive-off waveform, 1 the drive-on waveform.
`include "lsd_cfg.svh"
module lsd_driver #(
    parameter int NUM_SEG = `LSD_NUM_SEG,
    parameter int NUM_COM = `LSD_NUM_COM,
    parameter int STEP_CYCLES = `LSD_STEP_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port
    input wire lsd_pkg::lsd_bus_t bus,
    output logic [`LSD_DATA_W-1:0] rdata,
    // Bias generator control
    output logic biasEnable,
    output logic [1:0] biasMode,
    // Display pins
    output lsd_pkg::lsd_pin_t [NUM_COM-1:0] comPin,
    output lsd_pkg::lsd_pin_t [NUM_SEG-1:0] segPin,
    output logic displayOn
);
    import lsd_pkg::*;

    localparam int DW = `LSD_DATA_W;

    // Display data storage, undefined until software loads it
    logic [NUM_COM-1:0] dispData [0:NUM_SEG-1];
    logic [NUM_SEG-1:0] segSel;
    logic [NUM_SEG-1:0] next_segSel;
    lsd_dcfg_t dcfg;
    lsd_dcfg_t next_dcfg;
    lsd_bcfg_t bcfg;
    lsd_bcfg_t next_bcfg;
    lsd_mode_t mode;
    lsd_mode_t next_mode;
    logic configured;
    logic next_configured;
    logic [DW-1:0] next_rdata;

    // Frame-phase state
    logic [23:0] divCnt;
    logic [23:0] next_divCnt;
    logic [1:0] slot;
    logic [1:0] next_slot;
    logic pol;
    logic next_pol;

    // Pin values built from next state, so pins move with the registers
    wire lsd_pin_t [NUM_COM-1:0] next_comPin;
    wire lsd_pin_t [NUM_SEG-1:0] next_segPin;
    logic nextRunning;
    logic [1:0] nextLastSlot;

    // Address decode
    logic running;
    logic hitData;
    logic hitSegSel;
    logic [2:0] segIdx;
    logic [23:0] stepLimit;
    logic [1:0] lastSlot;
    logic useB;

    assign running = (mode != LSD_STOP);
    assign hitData = (bus.addr <= `LSD_OFF_DATA_LAST);
    assign segIdx = bus.addr[3:1];
    assign hitSegSel = (bus.addr[7:4] == `LSD_OFF_SEGSEL_BASE >> 4) && !bus.addr[0]
                       && (segIdx <= `LSD_SEGSEL_LAST_IDX);
    assign stepLimit = 24'(STEP_CYCLES) >> dcfg.freqSel;
    assign lastSlot = dcfg.duty4 ? 2'h3 : 2'h2;
    assign useB = dcfg.waveB && !dcfg.ledMode;
    assign nextRunning = (next_mode != LSD_STOP);
    assign nextLastSlot = next_dcfg.duty4 ? 2'h3 : 2'h2;

    // Display data writes, low NUM_COM bits of the port
    always_ff @(posedge mclk) begin
        if (bus.wr && hitData) begin
            dispData[bus.addr[6:0]] <= bus.wdata[NUM_COM-1:0];
        end
    end

    // Control register next values and read mux
    always_comb begin
        next_segSel = segSel;
        next_dcfg = dcfg;
        next_bcfg = bcfg;
        next_mode = mode;
        next_configured = configured;
        next_rdata = '0;
        if (bus.wr) begin
            if (hitSegSel && !running) begin
                for (int i = 0; i < 4; i++) begin
                    if (segIdx == 3'(i)) begin
                        next_segSel[16*i +: 16] = bus.wdata;
                    end
                end
                if (segIdx == `LSD_SEGSEL_LAST_IDX) begin
                    next_segSel[NUM_SEG-1] = bus.wdata[0];
                end
            end
            if (bus.addr == `LSD_OFF_DCFG) begin
                next_dcfg = bus.wdata[4:0];
                next_configured = 1'b1;
            end
            if (bus.addr == `LSD_OFF_BCFG) begin
                next_bcfg = {bus.wdata[4], bus.wdata[1:0]};
            end
            if (bus.addr == `LSD_OFF_DCTL) begin
                next_mode = lsd_mode_t'(bus.wdata[1:0]);
            end
        end
        if (bus.rd) begin
            if (hitData) begin
                next_rdata = DW'(dispData[bus.addr[6:0]]);
            end else if (hitSegSel) begin
                if (segIdx == `LSD_SEGSEL_LAST_IDX) begin
                    next_rdata = DW'(segSel[NUM_SEG-1]);
                end else begin
                    next_rdata = segSel[16*segIdx +: 16];
                end
            end else if (bus.addr == `LSD_OFF_DCFG) begin
                next_rdata = DW'(dcfg);
            end else if (bus.addr == `LSD_OFF_BCFG) begin
                next_rdata = DW'({bcfg.biasOn, 2'h0, bcfg.biasMode});
            end else if (bus.addr == `LSD_OFF_DCTL) begin
                next_rdata = DW'(mode);
            end else if (bus.addr == `LSD_OFF_STAT) begin
                next_rdata = DW'({configured, pol, slot, running});
            end
        end
    end

    // Control registers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            segSel <= '0;
            dcfg <= `LSD_DCFG_RST;
            bcfg <= `LSD_BCFG_RST;
            mode <= LSD_STOP;
            configured <= 1'b0;
            rdata <= '0;
        end else begin
            segSel <= next_segSel;
            dcfg <= next_dcfg;
            bcfg <= next_bcfg;
            mode <= next_mode;
            configured <= next_configured;
            rdata <= next_rdata;
        end
    end

    // Frame-phase counter: type A flips polarity each step, B each frame
    always_comb begin
        next_divCnt = divCnt;
        next_slot = slot;
        next_pol = pol;
        if (!running) begin
            next_divCnt = '0;
            next_slot = '0;
            next_pol = 1'b0;
        end else if (divCnt >= stepLimit - 24'h1) begin
            next_divCnt = '0;
            if (!useB) begin
                next_pol = !pol;
                if (pol) begin
                    next_slot = (slot == lastSlot) ? 2'h0 : slot + 2'h1;
                end
            end else begin
                next_slot = (slot == lastSlot) ? 2'h0 : slot + 2'h1;
                if (slot == lastSlot) begin
                    next_pol = !pol;
                end
            end
        end else begin
            next_divCnt = divCnt + 24'h1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            divCnt <= '0;
            slot <= '0;
            pol <= 1'b0;
        end else begin
            divCnt <= next_divCnt;
            slot <= next_slot;
            pol <= next_pol;
        end
    end

    // One drive cell per common, fed from the next frame phase
    for (genvar i = 0; i < NUM_COM; i++) begin : gen_com
        lsd_com_cell #(
            .IDX(i)
        ) lsd_com_cell_inst (
            .slot(next_slot),
            .pol(next_pol),
            .lastSlot(nextLastSlot),
            .configured(next_configured),
            .running(nextRunning),
            .ledMode(next_dcfg.ledMode),
            .pin(next_comPin[i])
        );
    end

    // One drive cell per segment; data writes reach the pins one edge later
    for (genvar j = 0; j < NUM_SEG; j++) begin : gen_seg
        lsd_seg_cell #(
            .NUM_COM(NUM_COM)
        ) lsd_seg_cell_inst (
            .sel(next_segSel[j]),
            .data(dispData[j]),
            .slot(next_slot),
            .pol(next_pol),
            .mode(next_mode),
            .ledMode(next_dcfg.ledMode),
            .pin(next_segPin[j])
        );
    end

    // Pin and bias outputs
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            comPin <= '0;
            segPin <= '0;
            biasEnable <= 1'b0;
            biasMode <= 2'h0;
            displayOn <= 1'b0;
        end else begin
            comPin <= next_comPin;
            segPin <= next_segPin;
            biasEnable <= next_bcfg.biasOn && (next_bcfg.biasMode != `LSD_BIAS_EXT);
            biasMode <= next_bcfg.biasMode;
            displayOn <= (next_mode != LSD_STOP);
        end
    end
endmodule // lsd_driver

module lsd_com_cell #(
    parameter int IDX = 0
) (
    // Frame phase
    input wire logic [1:0] slot,
    input wire logic pol,
    // Configuration
    input wire logic [1:0] lastSlot,
    input wire logic configured,
    input wire logic running,
    input wire logic ledMode,
    // Pin drive
    output lsd_pkg::lsd_pin_t pin
);
    import lsd_pkg::*;

    logic sel;

    assign sel = (slot == 2'(IDX));

    // Used commons drive ground while stopped once configured, then the frame pattern
    always_comb begin
        pin = '{oe: 1'b0, level: `LSD_LVL_VSS};
        if (2'(IDX) <= lastSlot && configured) begin
            pin.oe = 1'b1;
            if (running) begin
                if (ledMode) begin
                    pin.level = sel ? `LSD_LVL_V3 : `LSD_LVL_VSS;
                end else if (sel) begin
                    pin.level = pol ? `LSD_LVL_VSS : `LSD_LVL_V3;
                end else begin
                    pin.level = pol ? `LSD_LVL_V2 : `LSD_LVL_V1;
                end
            end
        end
    end
endmodule // lsd_com_cell

module lsd_seg_cell #(
    parameter int NUM_COM = 4
) (
    // Segment state
    input wire logic sel,
    input wire logic [NUM_COM-1:0] data,
    // Frame phase
    input wire logic [1:0] slot,
    input wire logic pol,
    // Configuration
    input wire lsd_pkg::lsd_mode_t mode,
    input wire logic ledMode,
    // Pin drive
    output lsd_pkg::lsd_pin_t pin
);
    import lsd_pkg::*;

    logic on;

    // Drive-on or drive-off choice for the current common
    always_comb begin
        unique case (mode)
            LSD_STOP: on = 1'b0;
            LSD_NORMAL: on = data[slot];
            LSD_BLANK: on = 1'b0;
            LSD_ALLON: on = 1'b1;
        endcase
    end

    // Selected segments sit at ground until the display runs
    always_comb begin
        pin = '{oe: sel, level: `LSD_LVL_VSS};
        if (mode != LSD_STOP && sel) begin
            if (ledMode) begin
                pin.level = on ? `LSD_LVL_V3 : `LSD_LVL_VSS;
            end else if (on) begin
                pin.level = pol ? `LSD_LVL_V3 : `LSD_LVL_VSS;
            end else begin
                pin.level = pol ? `LSD_LVL_V1 : `LSD_LVL_V2;
            end
        end
    end
endmodule // lsd_seg_cell

// ==== rtl/lsd_cfg.svh ====
`ifndef LSD_CFG_SVH
`define LSD_CFG_SVH

// Bus and pin dimensions
`define LSD_ADDR_W 8
`define LSD_DATA_W 16
`define LSD_NUM_SEG 65
`define LSD_NUM_COM 4

// Register offsets (byte addresses on the local port)
`define LSD_OFF_DATA_FIRST 8'h00
`define LSD_OFF_DATA_LAST 8'h40
`define LSD_OFF_SEGSEL_BASE 8'h60
`define LSD_SEGSEL_LAST_IDX 3'h4
`define LSD_OFF_DCFG 8'h70
`define LSD_OFF_BCFG 8'h72
`define LSD_OFF_DCTL 8'h74
`define LSD_OFF_STAT 8'h76

// Reset values
`define LSD_DCFG_RST 5'h00
`define LSD_BCFG_RST 3'h0

// Bias generator mode that takes an external supply
`define LSD_BIAS_EXT 2'h3

// Drive levels on a pin: ground, then rising bias steps
`define LSD_LVL_VSS 2'h0
`define LSD_LVL_V1 2'h1
`define LSD_LVL_V2 2'h2
`define LSD_LVL_V3 2'h3

// Frame timing: one waveform step at the slowest frame rate
`define LSD_STEP_NS 1953120
`define LSD_CLK_NS 10
`define LSD_STEP_CYCLES (`LSD_STEP_NS / `LSD_CLK_NS)

`endif

// ==== rtl/lsd_pkg.sv ====
package lsd_pkg;
    `include "lsd_cfg.svh"

    // Display-mode field of display_control_reg
    typedef enum logic [1:0] {
        LSD_STOP = 2'b00,
        LSD_NORMAL = 2'b01,
        LSD_BLANK = 2'b10,
        LSD_ALLON = 2'b11
    } lsd_mode_t;

    // display_config_reg layout
    typedef struct packed {
        logic [1:0] freqSel;
        logic ledMode;
        logic waveB;
        logic duty4;
    } lsd_dcfg_t;

    // bias_config_reg layout
    typedef struct packed {
        logic biasOn;
        logic [1:0] biasMode;
    } lsd_bcfg_t;

    // One common or segment pin
    typedef struct packed {
        logic oe;
        logic [1:0] level;
    } lsd_pin_t;

    // Register port request
    typedef struct packed {
        logic [`LSD_ADDR_W-1:0] addr;
        logic [`LSD_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } lsd_bus_t;
endpackage

// ==== tb/lsd_chk.sv ====
`timescale 1ns/1ns
`include "lsd_cfg.svh"
module lsd_chk #(
    parameter int NUM_SEG = 65,
    parameter int NUM_COM = 4,
    parameter int STEP_CYCLES = 4
) (
    // Clock, reset and register port
    input wire logic mclk,
    input wire logic sys_rst,
    input wire lsd_pkg::lsd_bus_t bus,
    input wire logic [`LSD_DATA_W-1:0] rdata,
    // Bias and pins
    input wire logic biasEnable,
    input wire logic [1:0] biasMode,
    input wire lsd_pkg::lsd_pin_t [NUM_COM-1:0] comPin,
    input wire lsd_pkg::lsd_pin_t [NUM_SEG-1:0] segPin,
    input wire logic displayOn
);
    import lsd_pkg::*;
    lsd_pin_t [NUM_SEG+NUM_COM-1:0] allPin;
    logic [NUM_SEG-1:0] segOe;
    logic anyOe, notVss, midLvl;
    logic [4:0] cfg;
    assign allPin = {comPin, segPin};
    // Pin summaries
    always_comb begin
        anyOe = 1'b0;
        notVss = 1'b0;
        midLvl = 1'b0;
        foreach (allPin[i]) begin
            anyOe |= allPin[i].oe;
            notVss |= allPin[i].oe && allPin[i].level != `LSD_LVL_VSS;
            midLvl |= allPin[i].oe && allPin[i].level inside {`LSD_LVL_V1, `LSD_LVL_V2};
        end
        foreach (segPin[i]) segOe[i] = segPin[i].oe;
    end
    // Shadow of the display config
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) cfg <= 5'h00;
        else if (bus.wr && bus.addr == `LSD_OFF_DCFG) cfg <= bus.wdata[4:0];
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence dctlWr;
        bus.wr && bus.addr == `LSD_OFF_DCTL;
    endsequence
    sequence selWr;
        bus.wr && bus.addr inside {[8'h60:8'h68]};
    endsequence
    AST_RST_FLOAT: assert property (disable iff (1'b0) sys_rst |=> !anyOe && !displayOn)
        else $error("pins driven in reset");
    AST_MODE_RUN: assert property (dctlWr |=> displayOn == ($past(bus.wdata[1:0]) != 2'h0))
        else $error("display state wrong after control write");
    AST_BIAS_ON: assert property (bus.wr && bus.addr == `LSD_OFF_BCFG |=>
        biasEnable == ($past(bus.wdata[4]) && $past(bus.wdata[1:0]) != `LSD_BIAS_EXT))
        else $error("bias enable wrong");
    AST_STOP_GND: assert property (!displayOn |-> !notVss)
        else $error("driven pin not at ground while stopped");
    AST_COM_UNUSED: assert property (!cfg[0] |-> !comPin[NUM_COM-1].oe)
        else $error("unused common driven");
    AST_SEL_LOCK: assert property (selWr and displayOn |=> $stable(segOe)[*2])
        else $error("segment select changed while running");
    AST_LED_LVL: assert property (displayOn && cfg[2] |-> !midLvl)
        else $error("mid level in LED mode");
    AST_STEP_HOLD: assert property (STEP_CYCLES == 4 && cfg[4:3] == 2'h0 && displayOn
        && $past(displayOn) && $changed(comPin) |=> ($stable(comPin) || !displayOn)[*3])
        else $error("common step too short");
endmodule // lsd_chk
bind lsd_driver lsd_chk #(.NUM_SEG(NUM_SEG), .NUM_COM(NUM_COM), .STEP_CYCLES(STEP_CYCLES))
    lsd_chk_inst (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .biasEnable(biasEnable), .biasMode(biasMode), .comPin(comPin), .segPin(segPin),
    .displayOn(displayOn));

// ==== tb/lsd_panel.sv ====
`timescale 1ns/1ns
module lsd_panel (
    // Clock and clear
    input wire logic mclk,
    input wire logic clr,
    // Electrodes of two pixels on common 0
    input wire lsd_pkg::lsd_pin_t com0,
    input wire lsd_pkg::lsd_pin_t seg0,
    input wire lsd_pkg::lsd_pin_t seg1,
    // Cycles at full bias per pixel
    output int lit0,
    output int lit1
);
    import lsd_pkg::*;
    // Full bias darkens a pixel; a floating electrode gives none
    function automatic bit full(lsd_pin_t c, lsd_pin_t s);
        return c.oe && s.oe && (c.level ^ s.level) == 2'h3 && c.level inside {2'h0, 2'h3};
    endfunction
    always @(posedge mclk) begin
        lit0 <= clr ? 0 : lit0 + int'(full(com0, seg0));
        lit1 <= clr ? 0 : lit1 + int'(full(com0, seg1));
    end
endmodule // lsd_panel

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    import lsd_pkg::*;
    logic mclk = 1'b0, sys_rst = 1'b1, clr = 1'b0, biasEnable, displayOn;
    lsd_bus_t bus = '0;
    logic [15:0] rdata, v, mdl [256];
    logic [1:0] biasMode;
    lsd_pin_t [3:0] comPin;
    lsd_pin_t [64:0] segPin;
    int lit0, lit1, error_cnt = 0, samples_checked = 0, cyc = 0;
    lsd_driver #(.STEP_CYCLES(4)) lsd_driver_inst (.mclk(mclk), .sys_rst(sys_rst), .bus(bus),
        .rdata(rdata), .biasEnable(biasEnable), .biasMode(biasMode), .comPin(comPin),
        .segPin(segPin), .displayOn(displayOn));
    lsd_panel lsd_panel_inst (.mclk(mclk), .clr(clr), .com0(comPin[0]), .seg0(segPin[0]),
        .seg1(segPin[1]), .lit0(lit0), .lit1(lit1));
    always #5 mclk = ~mclk;
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    // Readable bits of each register
    function automatic logic [15:0] msk(logic [7:0] a);
        if (a <= 8'h40) return 16'h000F;
        if (a inside {8'h60, 8'h62, 8'h64, 8'h66}) return 16'hFFFF;
        case (a)
            8'h68: return 16'h0001;
            8'h70: return 16'h001F;
            8'h72: return 16'h0013;
            8'h74: return 16'h0003;
            8'h76: return 16'h001F;
            default: return 16'h0000;
        endcase
    endfunction
    function automatic logic [15:0] segOe16();
        for (int i = 0; i < 16; i++) segOe16[i] = segPin[i].oe;
    endfunction
    function automatic logic [15:0] comOe();
        return {12'h000, comPin[3].oe, comPin[2].oe, comPin[1].oe, comPin[0].oe};
    endfunction
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Model refuses select writes while running
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge mclk);
        bus.wr <= 1'b0;
        if (!(a inside {[8'h60:8'h68]} && mdl[8'h74][1:0] != 2'h0)) mdl[a] = d & msk(a);
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 cmp(rdata, mdl[a] & msk(a), "rdata");
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        mdl = '{default: 16'h0000};
        v = 16'($urandom(32'h7AC223EC));
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        #1 cmp(comOe() | segOe16(), 16'h0000, "float");
        $display("test reset done");
        v = 16'($urandom) | 16'h0003;
        wr(8'h60, v);
        cmp(segOe16(), v, "seg select");
        wr(8'h70, 16'h0000);
        cmp(comOe(), 16'h0007, "com third");
        wr(8'h70, 16'h0001);
        cmp(comOe(), 16'h000F, "com quarter");
        for (int m = 0; m < 4; m++) begin
            wr(8'h72, 16'h0010 | 16'(m));
            cmp({15'h0, biasEnable}, {15'h0, m != 3}, "bias");
            cmp({14'h0, biasMode}, 16'(m), "bias mode");
        end
        rd(8'h60);
        rd(8'h72);
        rd(8'h50);
        mdl[8'h76] = 16'h0010; // Config written, stopped, phase at rest
        rd(8'h76);
        $display("test config done");
        wr(8'h00, 16'h0001);
        wr(8'h01, 16'h000E);
        wr(8'h72, 16'h0010);
        cmp({15'h0, biasEnable}, 16'h0001, "bias up");
        repeat (20) @(posedge mclk);
        for (int m = 1; m < 4; m++) begin
            clr <= 1'b1;
            wr(8'h74, 16'(m));
            clr <= 1'b0;
            wr(8'h60, ~v);
            repeat (64) @(posedge mclk);
            #1 cmp({15'h0, lit0 > 0}, {15'h0, m != 2}, "pixel 0");
            cmp({15'h0, lit1 > 0}, {15'h0, m == 3}, "pixel 1");
            rd(8'h60);
            wr(8'h74, 16'h0000);
        end
        $display("test pixels done");
        for (int c = 0; c < 8; c++) begin
            wr(8'h70, 16'(c));
            wr(8'h74, 16'h0001);
            repeat (40) @(posedge mclk);
            #1 cmp({15'h0, displayOn}, 16'h0001, "running");
            rd(8'h70);
            wr(8'h74, 16'h0000);
        end
        $display("test sweep done");
        repeat (16) begin
            v = 16'($urandom_range(0, 64));
            wr(v[7:0], 16'($urandom));
            rd(v[7:0]);
        end
        $display("test data done");
        wr(8'h74, 16'h0001);
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b1;
        @(posedge mclk);
        #1 cmp(comOe() | segOe16(), 16'h0000, "float again");
        cmp({15'h0, displayOn}, 16'h0000, "stopped");
        $display("test second reset done");
        stop_test();
    end
endmodule // tb_top
